// ### hdl/tty_receiver.sv
`default_nettype none
module tty_receiver #(
	parameter int ELEM_CYCLES = tty_pkg::ELEM_CYC,
	parameter int STOP_CYCLES = tty_pkg::STOP_CYC,
	parameter int FORM_LINES = 66,
	parameter logic [24:0] STATION_ID = 25'h0_0421,
	parameter logic [19:0] ANSWER_BACK = 20'h4_2b61
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Signal line, high is marking
	input wire logic i_line,
	output logic o_line,
	// Local controls
	input wire logic [6:0] i_margin,
	input wire logic [84:0] i_tab_cols,
	input wire logic [127:0] i_tab_lines,
	input wire logic i_answer_key,
	input wire logic i_motor_req,
	// Printer side
	output logic o_char_valid,
	output logic [4:0] o_char,
	input wire logic i_char_ready,
	output logic [6:0] o_column,
	output logic [6:0] o_line_no,
	output logic o_carriage_return,
	output logic o_line_feed,
	output logic o_non_print,
	output logic o_motor_on,
	output logic o_framing_err
);
	// ==========================================================
	// Receive framing
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	localparam int CNT_W = 24;
	localparam logic [CNT_W-1:0] ELEM_N = CNT_W'(ELEM_CYCLES - 1);
	localparam logic [CNT_W-1:0] HALF_N = CNT_W'(ELEM_CYCLES / 2 - 1);
	localparam logic [CNT_W-1:0] STOP_N = CNT_W'(STOP_CYCLES - ELEM_CYCLES / 2 - 1);

	rx_state_t rx_ff;
	logic [CNT_W-1:0] tmr_ff;
	logic [2:0] bit_ff;
	logic [4:0] shf_ff;
	logic line_d_ff;
	logic char_stb_ff;
	logic [4:0] char_ff;
	logic err_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_ff <= RX_IDLE;
			tmr_ff <= '0;
			bit_ff <= 3'h0;
			shf_ff <= 5'h00;
			line_d_ff <= 1'b1;
			char_stb_ff <= 1'b0;
			char_ff <= 5'h00;
			err_ff <= 1'b0;
		end else if (i_ce) begin
			line_d_ff <= i_line;
			char_stb_ff <= 1'b0;
			case (rx_ff)
				RX_IDLE: begin
					// Falling edge of the line marks the start element
					if (line_d_ff && !i_line) begin
						rx_ff <= RX_START;
						tmr_ff <= HALF_N;
					end
				end
				RX_START: begin
					if (tmr_ff != '0) begin
						tmr_ff <= tmr_ff - 1'b1;
					end else if (i_line) begin
						// Glitch shorter than half an element is rejected
						rx_ff <= RX_IDLE;
					end else begin
						rx_ff <= RX_DATA;
						tmr_ff <= ELEM_N;
						bit_ff <= 3'h0;
					end
				end
				RX_DATA: begin
					if (tmr_ff != '0) begin
						tmr_ff <= tmr_ff - 1'b1;
					end else begin
						shf_ff <= {i_line, shf_ff[4:1]};
						tmr_ff <= ELEM_N;
						if (bit_ff == 3'(tty_pkg::DATA_BITS - 1)) begin
							rx_ff <= RX_STOP;
						end
						bit_ff <= bit_ff + 3'h1;
					end
				end
				RX_STOP: begin
					if (tmr_ff != '0) begin
						tmr_ff <= tmr_ff - 1'b1;
					end else begin
						// Stop sampled at centre; STOP_N is loaded but idle does not wait out the rest of the stop
						err_ff <= !i_line;
						char_stb_ff <= i_line;
						char_ff <= shf_ff;
						rx_ff <= RX_IDLE;
						tmr_ff <= STOP_N;
					end
				end
				default: rx_ff <= RX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Selective calling
	logic non_print_ff;
	logic [1:0] id_pos_ff;
	logic [4:0] id_char;

	assign id_char = STATION_ID[5*id_pos_ff +: 5];

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			non_print_ff <= 1'b0;
			id_pos_ff <= 2'h0;
		end else if (i_ce && char_stb_ff) begin
			// Release code returns the unit to normal printing; a completed call below wins
			if (non_print_ff && char_ff == tty_pkg::CODE_DESEL) begin
				non_print_ff <= 1'b0;
			end
			if (char_ff == id_char) begin
				if (id_pos_ff == 2'(tty_pkg::ID_LEN - 1)) begin
					non_print_ff <= 1'b1;
					id_pos_ff <= 2'h0;
				end else begin
					id_pos_ff <= id_pos_ff + 2'h1;
				end
			end else begin
				id_pos_ff <= 2'h0;
			end
		end
	end

	// ==========================================================
	// Function decode and carriage position
	logic active;
	logic is_func;
	logic [6:0] col_ff;
	logic [6:0] ln_ff;
	logic cr_ff;
	logic lf_ff;
	logic [6:0] margin;
	logic [6:0] next_tab;
	logic [6:0] next_vt;

	assign active = char_stb_ff && !non_print_ff;
	assign is_func = (char_ff == tty_pkg::CODE_CR) || (char_ff == tty_pkg::CODE_LF) ||
		(char_ff == tty_pkg::CODE_HT) || (char_ff == tty_pkg::CODE_VT) ||
		(char_ff == tty_pkg::CODE_FF) || (char_ff == tty_pkg::CODE_WRU) ||
		(char_ff == tty_pkg::CODE_DESEL);
	// Out-of-range settings clamp to the documented span
	assign margin = (i_margin == 7'h00) ? tty_pkg::COL_FIRST :
		(i_margin > tty_pkg::MARGIN_MAX) ? tty_pkg::MARGIN_MAX : i_margin;

	always_comb begin
		next_tab = margin;
		for (int c = 84; c >= 1; c--) begin
			if (i_tab_cols[c] && 7'(c + 1) > col_ff && 7'(c + 1) <= margin) begin
				next_tab = 7'(c + 1);
			end
		end
	end

	always_comb begin
		next_vt = tty_pkg::COL_FIRST;
		for (int l = 127; l >= 0; l--) begin
			if (i_tab_lines[l] && 7'(l) > ln_ff && l < FORM_LINES) begin
				next_vt = 7'(l);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			col_ff <= tty_pkg::COL_FIRST;
			ln_ff <= 7'h00;
			cr_ff <= 1'b0;
			lf_ff <= 1'b0;
		end else if (i_ce) begin
			cr_ff <= 1'b0;
			lf_ff <= 1'b0;
			if (active) begin
				if (char_ff == tty_pkg::CODE_CR) begin
					col_ff <= tty_pkg::COL_FIRST;
					cr_ff <= 1'b1;
				end else if (char_ff == tty_pkg::CODE_LF) begin
					ln_ff <= (ln_ff == 7'(FORM_LINES - 1)) ? 7'h00 : ln_ff + 7'h01;
					lf_ff <= 1'b1;
				end else if (char_ff == tty_pkg::CODE_HT) begin
					col_ff <= next_tab;
				end else if (char_ff == tty_pkg::CODE_VT) begin
					ln_ff <= next_vt;
					lf_ff <= 1'b1;
				end else if (char_ff == tty_pkg::CODE_FF) begin
					ln_ff <= 7'h00;
					lf_ff <= 1'b1;
				end else if (!is_func) begin
					if (col_ff >= margin) begin
						// Both actions in one step when sender omitted them
						col_ff <= tty_pkg::COL_FIRST;
						ln_ff <= (ln_ff == 7'(FORM_LINES - 1)) ? 7'h00 : ln_ff + 7'h01;
						cr_ff <= 1'b1;
						lf_ff <= 1'b1;
					end else begin
						col_ff <= col_ff + 7'h01;
					end
				end
			end
		end
	end

	// ==========================================================
	// Print path through two-entry buffer
	logic buf_ready;
	logic buf_valid;
	logic [4:0] buf_data;
	logic print_push;

	// Printables only, and none while deselected
	assign print_push = active && !is_func;

	tty_skid #(.W(5)) u_buf (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_valid(print_push),
		.i_data(char_ff),
		.o_ready(buf_ready),
		.o_valid(buf_valid),
		.o_data(buf_data),
		.i_ready(!o_char_valid || i_char_ready)
	);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_char_valid <= 1'b0;
			o_char <= 5'h00;
		end else if (i_ce) begin
			if (!o_char_valid || i_char_ready) begin
				o_char_valid <= buf_valid;
				o_char <= buf_data;
			end
		end
	end

	// ==========================================================
	// Motor control and answer-back
	localparam int IDLE_W = 32;
	logic [IDLE_W-1:0] idle_ff;
	logic motor_ff;
	logic ab_req_ff;
	logic [3:0] ab_pos_ff;
	logic [CNT_W-1:0] ab_tmr_ff;
	logic [6:0] ab_shf_ff;
	logic [2:0] ab_bit_ff;
	logic tx_ff;
	logic ab_busy;

	assign ab_busy = (ab_bit_ff != 3'h0);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			idle_ff <= '0;
			motor_ff <= 1'b0;
		end else if (i_ce) begin
			// Any space on the line, or local demand, keeps the motor running
			if (!i_line || i_motor_req || ab_busy || ab_req_ff) begin
				idle_ff <= '0;
				motor_ff <= 1'b1;
			end else if (idle_ff == IDLE_W'(tty_pkg::IDLE_CHARS * STOP_CYCLES * 8)) begin
				motor_ff <= 1'b0;
			end else begin
				idle_ff <= idle_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ab_req_ff <= 1'b0;
			ab_pos_ff <= 4'h0;
			ab_tmr_ff <= '0;
			ab_shf_ff <= 7'h7f;
			ab_bit_ff <= 3'h0;
			tx_ff <= 1'b1;
		end else if (i_ce) begin
			// Request is taken even while a sequence is going out
			if (i_answer_key || (active && char_ff == tty_pkg::CODE_WRU)) begin
				ab_req_ff <= 1'b1;
			end else if (!ab_busy && ab_req_ff && ab_pos_ff == 4'(tty_pkg::AB_LEN)) begin
				ab_req_ff <= 1'b0;
			end
			if (ab_busy) begin
				if (ab_tmr_ff != '0) begin
					ab_tmr_ff <= ab_tmr_ff - 1'b1;
				end else begin
					tx_ff <= ab_shf_ff[0];
					ab_shf_ff <= {1'b1, ab_shf_ff[6:1]};
					ab_bit_ff <= ab_bit_ff - 3'h1;
					ab_tmr_ff <= (ab_bit_ff == 3'h2) ? CNT_W'(STOP_CYCLES - 1) : ELEM_N;
				end
			end else if (ab_req_ff && ab_pos_ff != 4'(tty_pkg::AB_LEN)) begin
				tx_ff <= 1'b0;
				// Data elements first, then two marking slots that form the stop
				ab_shf_ff <= {2'b11, ANSWER_BACK[5*ab_pos_ff +: 5]};
				ab_bit_ff <= 3'h7;
				ab_tmr_ff <= ELEM_N;
				ab_pos_ff <= ab_pos_ff + 4'h1;
			end else if (!ab_req_ff) begin
				ab_pos_ff <= 4'h0;
			end
		end
	end

	// ==========================================================
	// Output registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_line <= 1'b1;
			o_column <= tty_pkg::COL_FIRST;
			o_line_no <= 7'h00;
			o_carriage_return <= 1'b0;
			o_line_feed <= 1'b0;
			o_non_print <= 1'b0;
			o_motor_on <= 1'b0;
			o_framing_err <= 1'b0;
		end else if (i_ce) begin
			o_line <= tx_ff;
			o_column <= col_ff;
			o_line_no <= ln_ff;
			o_carriage_return <= cr_ff;
			o_line_feed <= lf_ff;
			o_non_print <= non_print_ff;
			o_motor_on <= motor_ff;
			o_framing_err <= err_ff;
		end
	end

	// ==========================================================
	// Checks
	sequence start_seen_s;
		rx_ff == RX_IDLE && line_d_ff && !i_line;
	endsequence

	auto_crlf_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && active && !is_func && col_ff >= margin) |=> cr_ff && lf_ff &&
		col_ff == tty_pkg::COL_FIRST)
		else $error("margin did not force return and feed");
	start_detect_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(start_seen_s and (i_ce == 1'b1)) |=> rx_ff == RX_START)
		else $error("start element missed");
	non_print_a: assert property (@(posedge i_clk) disable iff (i_rst)
		non_print_ff |-> !print_push)
		else $error("printing while deselected");
	no_function_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && non_print_ff && char_stb_ff) |=> !cr_ff && !lf_ff && $stable(col_ff))
		else $error("function done while deselected");
	five_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && rx_ff == RX_DATA && $past(rx_ff) == RX_START) |-> bit_ff == 3'h0)
		else $error("data count not restarted");
	margin_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
		margin >= tty_pkg::COL_FIRST && margin <= tty_pkg::MARGIN_MAX)
		else $error("margin out of range");
	form_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && active && char_ff == tty_pkg::CODE_FF) |=> ln_ff == 7'h00)
		else $error("form out missed top line");
	elem_time_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && rx_ff == RX_START && tmr_ff == '0 && !i_line) |=> tmr_ff == ELEM_N)
		else $error("element period wrong");
	motor_on_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && !i_line) |=> motor_ff)
		else $error("motor off during traffic");
	select_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && char_stb_ff && char_ff == id_char &&
		id_pos_ff == 2'(tty_pkg::ID_LEN - 1) && char_ff != tty_pkg::CODE_DESEL) |=> non_print_ff)
		else $error("own code not selected");
endmodule
`default_nettype wire

// ### hdl/tty_pkg.sv
`default_nettype none
package tty_pkg;
	localparam int CLK_HZ = 40000000;
	// Element and stop times in microseconds, fastest rated speed
	localparam int ELEM_US = 13500;
	localparam int STOP_US = 19100;
	localparam int ELEM_CYC = (ELEM_US * (CLK_HZ / 1000000));
	localparam int STOP_CYC = (STOP_US * (CLK_HZ / 1000000));
	localparam int HALF_CYC = ELEM_CYC / 2;
	localparam int DATA_BITS = 5;
	localparam int COL_W = 7;
	localparam int LINE_W = 7;
	localparam logic [6:0] MARGIN_MAX = 7'h55;
	localparam logic [6:0] COL_FIRST = 7'h01;
	localparam logic [4:0] CODE_CR = 5'h08;
	localparam logic [4:0] CODE_LF = 5'h02;
	localparam logic [4:0] CODE_HT = 5'h09;
	localparam logic [4:0] CODE_VT = 5'h0f;
	localparam logic [4:0] CODE_FF = 5'h1e;
	localparam logic [4:0] CODE_WRU = 5'h12;
	localparam logic [4:0] CODE_DESEL = 5'h17;
	localparam logic [4:0] CODE_IDLE_MARK = 5'h1f;
	localparam int IDLE_CHARS = 16;
	localparam int ID_LEN = 2;
	localparam int AB_LEN = 4;
endpackage
`default_nettype wire

// ### hdl/tty_skid.sv
`default_nettype none
module tty_skid #(
	parameter int W = 5
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Fill side
	input wire logic i_valid,
	input wire logic [W-1:0] i_data,
	output logic o_ready,
	// Drain side
	output logic o_valid,
	output logic [W-1:0] o_data,
	input wire logic i_ready
);
	logic [W-1:0] mem_ff [2];
	logic [1:0] cnt_ff;
	logic rd_ff;
	logic wr_ff;
	logic push;
	logic pop;

	assign push = i_valid && (cnt_ff != 2'h2);
	assign pop = (cnt_ff != 2'h0) && i_ready;
	assign o_ready = (cnt_ff != 2'h2);
	assign o_valid = (cnt_ff != 2'h0);
	assign o_data = mem_ff[rd_ff];

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= 2'h0;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
		end else if (i_ce) begin
			if (push) begin
				wr_ff <= ~wr_ff;
			end
			if (pop) begin
				rd_ff <= ~rd_ff;
			end
			cnt_ff <= 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce && push) begin
			mem_ff[wr_ff] <= i_data;
		end
	end
endmodule
`default_nettype wire

// ### testbench/line_station.sv
`default_nettype none
module line_station #(
	parameter int ELEM = 20,
	parameter int STOP = 28
) (
	input wire logic i_clk,
	input wire logic i_rx,
	output logic o_tx
);
	timeunit 1ns;
	timeprecision 100ps;

	initial o_tx = 1'b1;

	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask

	// ==========================================
	// Sending station, caller is just past an edge
	task automatic send_char(input logic [4:0] c, input logic bad_stop);
		o_tx = 1'b0;
		hold(ELEM);
		for (int i = 0; i < 5; i++) begin
			o_tx = c[i];
			hold(ELEM);
		end
		// A spacing stop is only sent when a scenario asks for a broken frame
		o_tx = ~bad_stop;
		hold(STOP);
		o_tx = 1'b1;
	endtask

	// ==========================================
	// Receiving station, samples element centres
	task automatic recv_char(output logic [4:0] c, output logic ok);
		int n;
		c = 5'h00;
		ok = 1'b0;
		n = 0;
		while (i_rx !== 1'b0 && n < 20000) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 20000) return;
		repeat (ELEM / 2) @(posedge i_clk);
		for (int i = 0; i < 5; i++) begin
			repeat (ELEM) @(posedge i_clk);
			c[i] = i_rx;
		end
		repeat (ELEM) @(posedge i_clk);
		ok = (i_rx === 1'b1);
	endtask
endmodule
`default_nettype wire

// ### testbench/start_stop_teleprinter_receiver_tb.sv
`default_nettype none
module start_stop_teleprinter_receiver_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int ELEM = 20;
	localparam int STOP = 28;
	// Arbitrary station and answer-back codes
	localparam logic [24:0] STATION = 25'h0_0421;
	localparam logic [19:0] ANSWER = 20'h4_2b61;
	logic clk, rst, line_in, line_out, ans_key, motor_req, char_ready;
	logic [6:0] margin, column, line_no;
	logic [84:0] tab_cols;
	logic [127:0] tab_lines;
	logic char_valid, cr, lf, non_print, motor_on, frame_err;
	logic [4:0] char_code;
	logic [4:0] got_q[$];
	int cr_cnt, both_cnt, failures, cmp_count;

	tty_receiver #(.ELEM_CYCLES(ELEM), .STOP_CYCLES(STOP), .STATION_ID(STATION),
		.ANSWER_BACK(ANSWER)) u_dut (.i_clk(clk), .i_rst(rst), .i_ce(1'b1),
		.i_line(line_in), .o_line(line_out), .i_margin(margin), .i_tab_cols(tab_cols),
		.i_tab_lines(tab_lines), .i_answer_key(ans_key), .i_motor_req(motor_req),
		.o_char_valid(char_valid), .o_char(char_code), .i_char_ready(char_ready),
		.o_column(column), .o_line_no(line_no), .o_carriage_return(cr),
		.o_line_feed(lf), .o_non_print(non_print), .o_motor_on(motor_on),
		.o_framing_err(frame_err));

	line_station #(.ELEM(ELEM), .STOP(STOP)) u_far (.i_clk(clk), .i_rx(line_out),
		.o_tx(line_in));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================
	// Printer side monitor
	always @(posedge clk) begin
		if (char_valid === 1'b1 && char_ready === 1'b1) got_q.push_back(char_code);
		if (cr === 1'b1) cr_cnt++;
		if (cr === 1'b1 && lf === 1'b1) both_cnt++;
	end

	task automatic tally_and_finish();
		if (failures == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tx(input logic [4:0] c);
		u_far.send_char(c, 1'b0);
		step(4);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_print();
		got_q.delete();
		tx(5'h05);
		check("char count", 7'h01, 7'(got_q.size()));
		check("char", 7'h05, 7'(got_q[0]));
	endtask

	task automatic t_functions();
		int c0;
		logic [6:0] l0;
		c0 = cr_cnt;
		tx(tty_pkg::CODE_CR);
		check("cr pulses", 7'h01, 7'(cr_cnt - c0));
		check("column", tty_pkg::COL_FIRST, column);
		l0 = line_no;
		tx(tty_pkg::CODE_LF);
		check("line", l0 + 7'h01, line_no);
		tx(tty_pkg::CODE_HT);
		check("tab column", 7'h0a, column);
		tx(tty_pkg::CODE_VT);
		check("tab line", 7'h05, line_no);
		tx(tty_pkg::CODE_FF);
		check("form line", 7'h00, line_no);
	endtask

	task automatic t_margin();
		int b0;
		margin = 7'h03;
		tx(tty_pkg::CODE_CR);
		b0 = both_cnt;
		for (int i = 0; i < 4; i++) tx(5'h05);
		check("auto cr lf", 7'h01, 7'(both_cnt - b0));
		margin = tty_pkg::MARGIN_MAX;
	endtask

	task automatic t_stall();
		got_q.delete();
		char_ready = 1'b0;
		// Two buffer entries plus the output register hold; the fourth is dropped
		for (int i = 3; i < 7; i++) tx(5'(i));
		char_ready = 1'b1;
		step(8);
		check("held count", 7'h03, 7'(got_q.size()));
		for (int i = 0; i < 3; i++) check("held char", 7'(i + 3), 7'(got_q[i]));
	endtask

	task automatic t_framing();
		got_q.delete();
		u_far.send_char(5'h06, 1'b1);
		step(4);
		check("framing err", 7'h01, 7'(frame_err));
		check("bad char dropped", 7'h00, 7'(got_q.size()));
	endtask

	task automatic t_select();
		int c0;
		tx(STATION[4:0]);
		tx(STATION[9:5]);
		check("non print", 7'h01, 7'(non_print));
		got_q.delete();
		c0 = cr_cnt;
		tx(5'h05);
		tx(tty_pkg::CODE_CR);
		check("suppressed", 7'h00, 7'(got_q.size()));
		check("no function", 7'h00, 7'(cr_cnt - c0));
		tx(tty_pkg::CODE_DESEL);
		check("deselected", 7'h00, 7'(non_print));
	endtask

	task automatic t_answer(input logic by_line);
		logic [4:0] c;
		logic ok;
		fork
			if (by_line) tx(tty_pkg::CODE_WRU);
			else begin
				ans_key = 1'b1;
				step(1);
				ans_key = 1'b0;
			end
			for (int k = 0; k < tty_pkg::AB_LEN; k++) begin
				u_far.recv_char(c, ok);
				check("answer frame", 7'h01, 7'(ok));
				check("answer char", 7'(ANSWER[k*5 +: 5]), 7'(c));
				if (ok !== 1'b1) tally_and_finish();
			end
		join
	endtask

	task automatic t_motor();
		check("motor on", 7'h01, 7'(motor_on));
		step(4000);
		check("motor off", 7'h00, 7'(motor_on));
		motor_req = 1'b1;
		step(3);
		check("motor held", 7'h01, 7'(motor_on));
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		tally_and_finish();
	end

	initial begin
		rst = 1'b1;
		ans_key = 1'b0;
		motor_req = 1'b0;
		char_ready = 1'b1;
		margin = tty_pkg::MARGIN_MAX;
		tab_cols = '0;
		tab_cols[9] = 1'b1;
		tab_lines = '0;
		tab_lines[5] = 1'b1;
		step(12);
		rst = 1'b0;
		step(4);
		t_print();
		t_functions();
		t_margin();
		t_stall();
		t_framing();
		t_select();
		t_answer(1'b0);
		t_answer(1'b1);
		t_motor();
		tally_and_finish();
	end
endmodule
`default_nettype wire
